// ==== hw/pin_ctrl_pkg.sv ====
/*
  Shared constants for the reset, alarm pin and rate-select control block:
  timing, APB register map, field positions and the three-level pad codes.
  Assumes a single 25 MHz system clock and an APB master with 32-bit data.
*/
// Operation
// - Holding the reset pin low returns all logic and registers to defaults; the rate-select decode and osc_rate_code_out keep following the pins.
// - Clock outputs stay disabled for the whole time reset is held.
// - No output clock after reset until the host has configured the block.
// - Interrupt select set: shared pin is a maskable interrupt, polarity per irq_polarity.
// - Clock-loss select set, interrupt clear: pin shows loss of input clock.
// - In clock-loss mode the pin's active level follows clkloss_polarity.
// - With no function selected the shared pin is high impedance.
// - The two rate-select inputs choose crystal or reference type and frequency.
// - Each rate input decodes low, middle or high; open reads middle; both high unsupported.
// - Input clocks from 2 kHz to 710 MHz are accepted.
package pin_ctrl_pkg;

  // Clock and input clock timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned IN_MIN_HZ = 2_000;
  localparam longint unsigned IN_MAX_HZ = 710_000_000;
  localparam int unsigned LOS_TIMEOUT_CYC = CLK_HZ / IN_MIN_HZ;
  localparam int unsigned HOST_WAIT_MS = 10;

  // APB register byte addresses
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] INT_STAT_ADDR = 12'h008;
  localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 12'h00c;

  // Control register fields
  localparam int CTRL_W = 6;
  localparam int CTRL_IRQ_SEL = 0;
  localparam int CTRL_IRQ_POL = 1;
  localparam int CTRL_CLK_SEL = 2;
  localparam int CTRL_CLK_POL = 3;
  localparam int CTRL_OUT_EN = 4;
  localparam int CTRL_SOFT_RST = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h0a;

  // Status register fields
  localparam int STAT_LOS = 0;
  localparam int STAT_RATE_BAD = 1;
  localparam int STAT_XTAL_RATE_SEL0_LSB = 2;
  localparam int STAT_XTAL_RATE_SEL1_LSB = 4;

  // Interrupt status and mask fields
  localparam int INT_W = 3;
  localparam int INT_LOS_SET = 0;
  localparam int INT_LOS_CLR = 1;
  localparam int INT_RATE_BAD = 2;
  localparam logic [INT_W-1:0] INT_RESET = 3'h0;

  // Decoded rate levels and pad comparator codes {above_high, above_low}
  typedef enum logic [1:0] {
    RATE_L = 2'b00,
    RATE_M = 2'b01,
    RATE_H = 2'b10
  } rate_level_t;
  localparam logic [1:0] PAD_L = 2'h0;
  localparam logic [1:0] PAD_H = 2'h3;

endpackage

// ==== hw/clk_loss_monitor.sv ====
/*
  Loss-of-signal monitor for the input clock: flags loss when no level change
  is seen for one period of the slowest legal input clock.
  Assumes ref_clock_in is asynchronous; high rates arrive prescaled by the pad.
*/
`timescale 1ns/100ps
`default_nettype none
module clk_loss_monitor #(
  parameter int unsigned TIMEOUT_CYC = pin_ctrl_pkg::LOS_TIMEOUT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic clear_in,
  input wire logic ref_clock_in,
  output logic loss_of_signal_out
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);

  // Refuse a timeout the counter cannot serve
  if (TIMEOUT_CYC < 2) begin : g_chk
    $error("TIMEOUT_CYC must be at least 2");
  end

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic [CW-1:0] cnt;
    logic loss_of_signal;
  } mon_t;

  mon_t q;
  mon_t d;

  // Edge watch and silence counter
  always_comb begin
    d = q;
    d.s1 = ref_clock_in;
    d.s2 = q.s1;
    d.prev = q.s2;
    if (clear_in) begin
      d.cnt = '0;
      d.loss_of_signal = 1'b0;
    end else if (q.s2 != q.prev) begin
      d.cnt = '0;
      d.loss_of_signal = 1'b0;
    end else if (q.cnt == CW'(TIMEOUT_CYC - 1)) begin
      d.loss_of_signal = 1'b1;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  // State register, frozen while ce_in is low
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end

  assign loss_of_signal_out = q.loss_of_signal;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  cnt_bound_a: assert property (q.cnt <= CW'(TIMEOUT_CYC - 1))
    else $error("silence counter ran past timeout");
  edge_clears_a: assert property (ce_in && !clear_in && q.s2 != q.prev |=> !q.loss_of_signal)
    else $error("loss flag kept despite input activity");
endmodule
`default_nettype wire

// ==== hw/rate_sel_decode.sv ====
/*
  Three-level rate-select decoder: synchronises the pad comparator pairs of
  both rate pins and decodes low, middle or high for the oscillator.
  Assumes the pad network pulls an open pin to mid-supply.
*/
`timescale 1ns/100ps
`default_nettype none
module rate_sel_decode (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic [1:0] xtal_rate_sel0_in,
  input wire logic [1:0] xtal_rate_sel1_in,
  output logic [1:0] xtal_rate_sel0_out,
  output logic [1:0] xtal_rate_sel1_out,
  output logic rate_bad_out
);
  typedef struct packed {
    logic [1:0] s1_0;
    logic [1:0] s1_1;
    logic [1:0] s2_0;
    logic [1:0] s2_1;
    logic [1:0] c0;
    logic [1:0] c1;
    logic bad;
  } dec_t;

  dec_t q;
  dec_t d;

  // Pad code to level; anything not clearly low or high reads middle
  function automatic logic [1:0] level(input logic [1:0] pad);
    case (pad)
      pin_ctrl_pkg::PAD_L: level = pin_ctrl_pkg::RATE_L;
      pin_ctrl_pkg::PAD_H: level = pin_ctrl_pkg::RATE_H;
      default: level = pin_ctrl_pkg::RATE_M;
    endcase
  endfunction

  // Synchronise and decode both pins
  always_comb begin
    d = q;
    d.s1_0 = xtal_rate_sel0_in;
    d.s1_1 = xtal_rate_sel1_in;
    d.s2_0 = q.s1_0;
    d.s2_1 = q.s1_1;
    d.c0 = level(q.s2_0);
    d.c1 = level(q.s2_1);
    d.bad = (d.c0 == pin_ctrl_pkg::RATE_H) && (d.c1 == pin_ctrl_pkg::RATE_H);
  end

  // State register, frozen while ce_in is low
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end

  assign xtal_rate_sel0_out = q.c0;
  assign xtal_rate_sel1_out = q.c1;
  assign rate_bad_out = q.bad;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  hh_flag_a: assert property (q.bad == (q.c0 == pin_ctrl_pkg::RATE_H && q.c1 == pin_ctrl_pkg::RATE_H))
    else $error("unsupported rate flag wrong");
endmodule
`default_nettype wire

// ==== hw/pin_ctrl.sv ====
/*
  Pin control block: external reset, clock output gating, shared interrupt
  or clock-loss alarm pin, rate-select decode, and an APB register file.
  Assumes one 25 MHz clock, an APB master on that clock and asynchronous pins.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_ctrl #(
  parameter int unsigned LOS_TIMEOUT_CYC = pin_ctrl_pkg::LOS_TIMEOUT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic ext_rst_n_in,
  input wire logic ref_clock_in,
  input wire logic [1:0] xtal_rate_sel0_in,
  input wire logic [1:0] xtal_rate_sel1_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [pin_ctrl_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [pin_ctrl_pkg::DATA_W-1:0] pwdata_in,
  output logic [pin_ctrl_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_out,
  output logic irq_or_clkloss_out,
  output logic irq_or_clkloss_oe_out,
  output logic clk_out_enable_out,
  output logic [3:0] osc_rate_code_out
);
  localparam int CW = pin_ctrl_pkg::CTRL_W;
  localparam int IW = pin_ctrl_pkg::INT_W;
  localparam int DW = pin_ctrl_pkg::DATA_W;

  typedef struct packed {
    logic rst_n_s1;
    logic rst_n_s2;
    logic [CW-1:0] ctrl;
    logic [IW-1:0] int_stat;
    logic [IW-1:0] int_mask;
    logic loss_of_signal;
    logic rate_bad;
    logic [3:0] rate;
    logic pready;
    logic pslverr;
    logic [DW-1:0] prdata;
    logic irq;
    logic pin_out;
    logic pin_oe;
    logic clk_en;
  } state_t;

  // Register defaults; the reset pin synchroniser starts in reset
  localparam state_t RST_S = '{
    ctrl: pin_ctrl_pkg::CTRL_RESET,
    int_stat: pin_ctrl_pkg::INT_RESET,
    int_mask: pin_ctrl_pkg::INT_RESET,
    default: '0
  };

  state_t q;
  state_t d;
  logic los_w;
  logic rate_bad_w;
  logic [1:0] xtal_rate_sel0_w;
  logic [1:0] xtal_rate_sel1_w;
  logic clear_w;
  logic wr;
  logic [IW-1:0] set;
  logic [IW-1:0] w1c;

  // Reset pin, soft reset and the loss monitor clear together
  assign clear_w = !q.rst_n_s2 || q.ctrl[pin_ctrl_pkg::CTRL_SOFT_RST];

  clk_loss_monitor #(
    .TIMEOUT_CYC(LOS_TIMEOUT_CYC)
  ) u_los (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .clear_in(clear_w),
    .ref_clock_in(ref_clock_in),
    .loss_of_signal_out(los_w)
  );

  rate_sel_decode u_rate (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .xtal_rate_sel0_in(xtal_rate_sel0_in),
    .xtal_rate_sel1_in(xtal_rate_sel1_in),
    .xtal_rate_sel0_out(xtal_rate_sel0_w),
    .xtal_rate_sel1_out(xtal_rate_sel1_w),
    .rate_bad_out(rate_bad_w)
  );

  // Next-state logic: APB, events, shared pin and reset override
  always_comb begin
    d = q;
    wr = psel_in && penable_in && q.pready && pwrite_in;
    set = '0;
    w1c = '0;
    d.rst_n_s1 = ext_rst_n_in;
    d.rst_n_s2 = q.rst_n_s1;
    d.loss_of_signal = los_w;
    d.rate_bad = rate_bad_w;
    d.rate = {xtal_rate_sel1_w, xtal_rate_sel0_w};
    // Events seen on rising or falling alarm levels
    set[pin_ctrl_pkg::INT_LOS_SET] = los_w && !q.loss_of_signal;
    set[pin_ctrl_pkg::INT_LOS_CLR] = !los_w && q.loss_of_signal;
    set[pin_ctrl_pkg::INT_RATE_BAD] = rate_bad_w && !q.rate_bad;
    // Access phase answered one cycle later from registers
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    if (psel_in && penable_in && !q.pready) begin
      d.pready = 1'b1;
      d.prdata = '0;
      case (paddr_in)
        pin_ctrl_pkg::CTRL_ADDR: begin
          d.prdata = DW'(q.ctrl);
        end
        pin_ctrl_pkg::STATUS_ADDR: begin
          d.prdata[pin_ctrl_pkg::STAT_LOS] = q.loss_of_signal;
          d.prdata[pin_ctrl_pkg::STAT_RATE_BAD] = q.rate_bad;
          d.prdata[pin_ctrl_pkg::STAT_XTAL_RATE_SEL0_LSB +: 2] = q.rate[1:0];
          d.prdata[pin_ctrl_pkg::STAT_XTAL_RATE_SEL1_LSB +: 2] = q.rate[3:2];
        end
        pin_ctrl_pkg::INT_STAT_ADDR: begin
          d.prdata = DW'(q.int_stat);
        end
        pin_ctrl_pkg::INT_MASK_ADDR: begin
          d.prdata = DW'(q.int_mask);
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
    end
    // Writes take effect on the edge that completes the transfer
    if (wr) begin
      case (paddr_in)
        pin_ctrl_pkg::CTRL_ADDR: d.ctrl = pwdata_in[CW-1:0];
        pin_ctrl_pkg::INT_STAT_ADDR: w1c = pwdata_in[IW-1:0];
        pin_ctrl_pkg::INT_MASK_ADDR: d.int_mask = pwdata_in[IW-1:0];
        default: ;
      endcase
    end
    // Sticky status: a new event wins over a clear in the same cycle
    d.int_stat = (q.int_stat & ~w1c) | set;
    d.irq = |(d.int_stat & d.int_mask);
    // Shared pin: interrupt first, then clock-loss alarm, else released
    if (d.ctrl[pin_ctrl_pkg::CTRL_IRQ_SEL]) begin
      d.pin_oe = 1'b1;
      d.pin_out = d.ctrl[pin_ctrl_pkg::CTRL_IRQ_POL] ? d.irq : !d.irq;
    end else if (d.ctrl[pin_ctrl_pkg::CTRL_CLK_SEL]) begin
      d.pin_oe = 1'b1;
      d.pin_out = d.ctrl[pin_ctrl_pkg::CTRL_CLK_POL] ? d.loss_of_signal : !d.loss_of_signal;
    end else begin
      d.pin_oe = 1'b0;
      d.pin_out = 1'b0;
    end
    // Output clock only once the host has enabled it
    d.clk_en = d.ctrl[pin_ctrl_pkg::CTRL_OUT_EN];
    // Reset pin low or soft reset: defaults, outputs off, pin released
    if (clear_w) begin
      d.ctrl = pin_ctrl_pkg::CTRL_RESET;
      d.int_stat = pin_ctrl_pkg::INT_RESET;
      d.int_mask = pin_ctrl_pkg::INT_RESET;
      d.irq = 1'b0;
      d.pin_oe = 1'b0;
      d.pin_out = 1'b0;
      d.clk_en = 1'b0;
    end
  end

  // State register, frozen while ce_in is low
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= RST_S;
    end else if (ce_in) begin
      q <= d;
    end
  end

  // All outputs straight from the state register
  assign prdata_out = q.prdata;
  assign pready_out = q.pready;
  assign pslverr_out = q.pslverr;
  assign irq_out = q.irq;
  assign irq_or_clkloss_out = q.pin_out;
  assign irq_or_clkloss_oe_out = q.pin_oe;
  assign clk_out_enable_out = q.clk_en;
  assign osc_rate_code_out = q.rate;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_rst_seen;
    ce_in && !q.rst_n_s2;
  endsequence

  sequence s_ctrl_on_write;
    ce_in && wr && paddr_in == pin_ctrl_pkg::CTRL_ADDR && pwdata_in[pin_ctrl_pkg::CTRL_OUT_EN];
  endsequence

  sequence s_los_rise;
    ce_in && los_w && !q.loss_of_signal;
  endsequence

  sequence s_access;
    ce_in && psel_in && penable_in && !q.pready;
  endsequence

  // Reset behaviour
  rst_cfg_a: assert property (s_rst_seen |=> q.ctrl == pin_ctrl_pkg::CTRL_RESET && q.int_mask == '0)
    else $error("registers not at defaults during reset");
  rst_clk_off_a: assert property (s_rst_seen |=> !clk_out_enable_out && !irq_or_clkloss_oe_out)
    else $error("outputs active during reset");
  cfg_clk_on_a: assert property ($rose(clk_out_enable_out) |-> $past(q.ctrl[pin_ctrl_pkg::CTRL_OUT_EN] == 1'b0)
                                 && q.ctrl[pin_ctrl_pkg::CTRL_OUT_EN])
    else $error("clock output enabled without configuration");
  cfg_write_a: assert property (s_ctrl_on_write ##0 !d.ctrl[pin_ctrl_pkg::CTRL_SOFT_RST] && !clear_w
                                |=> clk_out_enable_out)
    else $error("enable write did not start the clock output");

  // Shared pin behaviour
  irq_pin_a: assert property (q.ctrl[pin_ctrl_pkg::CTRL_IRQ_SEL]
    |-> q.pin_oe && q.pin_out == (q.ctrl[pin_ctrl_pkg::CTRL_IRQ_POL] ? q.irq : !q.irq))
    else $error("interrupt level wrong on shared pin");
  los_pin_a: assert property (!q.ctrl[pin_ctrl_pkg::CTRL_IRQ_SEL] && q.ctrl[pin_ctrl_pkg::CTRL_CLK_SEL]
    |-> q.pin_oe && q.pin_out == (q.ctrl[pin_ctrl_pkg::CTRL_CLK_POL] ? q.loss_of_signal : !q.loss_of_signal))
    else $error("clock-loss level wrong on shared pin");
  tristate_a: assert property (!q.ctrl[pin_ctrl_pkg::CTRL_IRQ_SEL] && !q.ctrl[pin_ctrl_pkg::CTRL_CLK_SEL]
    |-> !irq_or_clkloss_oe_out)
    else $error("shared pin driven with no function");

  // Events and bus answer
  los_event_a: assert property (s_los_rise ##0 !clear_w |=> q.int_stat[pin_ctrl_pkg::INT_LOS_SET])
    else $error("loss event not latched");
  set_wins_a: assert property (ce_in && !clear_w && set != '0 |=> (q.int_stat & $past(set)) == $past(set))
    else $error("event lost against clear");
  apb_answer_a: assert property (s_access |=> pready_out ##1 !pready_out)
    else $error("APB answer timing wrong");

  // Register writes, refused addresses and level changes of the alarms
  sequence s_ctrl_write;
    ce_in && wr && paddr_in == pin_ctrl_pkg::CTRL_ADDR && !clear_w;
  endsequence

  sequence s_mask_write;
    ce_in && wr && paddr_in == pin_ctrl_pkg::INT_MASK_ADDR && !clear_w;
  endsequence

  sequence s_bad_addr;
    s_access ##0 paddr_in != pin_ctrl_pkg::CTRL_ADDR && paddr_in != pin_ctrl_pkg::STATUS_ADDR
      && paddr_in != pin_ctrl_pkg::INT_STAT_ADDR && paddr_in != pin_ctrl_pkg::INT_MASK_ADDR;
  endsequence

  sequence s_los_fall;
    ce_in && !los_w && q.loss_of_signal;
  endsequence

  sequence s_hh_rise;
    ce_in && rate_bad_w && !q.rate_bad;
  endsequence

  // Register file contents
  ctrl_write_a: assert property (s_ctrl_write |=> q.ctrl == $past(pwdata_in[CW-1:0]))
    else $error("control write not stored");
  mask_write_a: assert property (s_mask_write |=> q.int_mask == $past(pwdata_in[IW-1:0]))
    else $error("mask write not stored");
  soft_clear_a: assert property (ce_in && q.ctrl[pin_ctrl_pkg::CTRL_SOFT_RST]
    |=> !q.ctrl[pin_ctrl_pkg::CTRL_SOFT_RST] && !clk_out_enable_out)
    else $error("soft reset did not clear itself");
  rst_clear_a: assert property (s_rst_seen |=> !irq_out && q.int_stat == '0)
    else $error("pending events kept during reset");
  clk_cfg_a: assert property (clk_out_enable_out |-> q.ctrl[pin_ctrl_pkg::CTRL_OUT_EN])
    else $error("clock output on without enable bit");

  // Bus error answer
  bad_addr_a: assert property (s_bad_addr |=> pslverr_out && pready_out && prdata_out == '0)
    else $error("unmapped access not refused");
  err_with_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error flag without ready");
  ready_pulse_a: assert property (ce_in && pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");

  // Events, interrupt level and status mirrors
  irq_level_a: assert property (irq_out == |(q.int_stat & q.int_mask))
    else $error("interrupt level does not match pending events");
  los_fall_a: assert property (s_los_fall ##0 !clear_w
    |=> q.int_stat[pin_ctrl_pkg::INT_LOS_CLR])
    else $error("loss end event not latched");
  hh_event_a: assert property (s_hh_rise ##0 !clear_w
    |=> q.int_stat[pin_ctrl_pkg::INT_RATE_BAD])
    else $error("unsupported rate event not latched");
  rate_code_a: assert property (ce_in |=> osc_rate_code_out == $past({xtal_rate_sel1_w, xtal_rate_sel0_w}))
    else $error("rate code not passed on");
  los_mirror_a: assert property (ce_in |=> q.loss_of_signal == $past(los_w))
    else $error("loss status not mirrored");
endmodule
`default_nettype wire

// ==== sim/ref_src_model.sv ====
/*
  Input clock source standing in for the far side of the pin control block.
  Assumes the system clock is faster than twice the generated clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ref_src_model (
  input wire logic sys_clk_in,
  input wire logic run_in,
  input wire logic [3:0] half_in,
  output logic ref_clock_out
);
  logic [3:0] cnt_q;
  initial begin
    ref_clock_out = 1'b0;
    cnt_q = 4'h0;
  end
  // Toggles every half_in cycles; stopping freezes the level like a lost input
  always @(posedge sys_clk_in) begin
    if (run_in) begin
      if (cnt_q + 4'h1 >= half_in) begin
        cnt_q <= 4'h0;
        ref_clock_out <= ~ref_clock_out;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
/*
  Self-checking bench for the pin control block: APB master, input clock
  source, rate pads and the external reset pin.
  Assumes the hand-over latencies: one APB wait state, four-edge pad decode.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk, rst, ext_n, run, psel, pen, pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [1:0] r0, r1, p0, p1;
  logic prdy, perr, irq, pin, oe, cken, refc, err_v;
  logic [3:0] rate;
  integer seed, err_total, num_checks, i;
  pin_ctrl #(.LOS_TIMEOUT_CYC(20)) dut (.sys_clk_in(clk), .sys_rst_in(rst), .ce_in(1'b1),
    .ext_rst_n_in(ext_n), .ref_clock_in(refc), .xtal_rate_sel0_in(r0), .xtal_rate_sel1_in(r1),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(prdy), .pslverr_out(perr), .irq_out(irq),
    .irq_or_clkloss_out(pin), .irq_or_clkloss_oe_out(oe), .clk_out_enable_out(cken),
    .osc_rate_code_out(rate));
  ref_src_model src (.sys_clk_in(clk), .run_in(run), .half_in(4'h3), .ref_clock_out(refc));
  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      end_sim();
    end else begin
      rd_v = prdata;
      err_v = perr;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  // Pad comparator pair to decoded level
  function automatic logic [1:0] lvl(input logic [1:0] p);
    return (p == 2'h0) ? 2'h0 : (p == 2'h3) ? 2'h2 : 2'h1;
  endfunction
  task pinchk(input logic [11:0] c, input logic e_oe, input logic e_pin);
    apb(1'b1, pin_ctrl_pkg::CTRL_ADDR, {20'h0_0000, c});
    cyc(3);
    chk("pin enable", 32'(e_oe), 32'(oe));
    chk("pin value", 32'(e_pin), 32'(pin));
  endtask
  initial begin
    {psel, pen, pwr, paddr, pwdata} = '0;
    rst = 1'b1;
    ext_n = 1'b1;
    run = 1'b1;
    r0 = 2'h1;
    r1 = 2'h1;
    seed = 19599;
    err_total = 0;
    num_checks = 0;
    cyc(12);
    rst <= 1'b0;
    cyc(3);
    apb(1'b0, pin_ctrl_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl reset", 32'h0000_000a, rd_v);
    chk("clock out", 32'h0, 32'(cken));
    chk("pin enable", 32'h0, 32'(oe));
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", 32'h0000_0001, 32'(err_v));
    // Random pad levels, first one the unsupported both-high case
    for (i = 0; i < 12; i++) begin
      p0 = 2'($random(seed));
      p1 = 2'($random(seed));
      if (i == 0) {p0, p1} = 4'hf;
      else if (p0 == 2'h3 && p1 == 2'h3) p1 = 2'h2;
      r0 <= p0;
      r1 <= p1;
      cyc(6);
      chk("rate code", 32'({lvl(p1), lvl(p0)}), 32'(rate));
      apb(1'b0, pin_ctrl_pkg::STATUS_ADDR, 32'h0);
      chk("rate bad", 32'(i == 0), 32'(rd_v[1]));
    end
    r0 <= 2'h1;
    r1 <= 2'h1;
    apb(1'b1, pin_ctrl_pkg::INT_STAT_ADDR, 32'h0000_0007);
    apb(1'b0, pin_ctrl_pkg::INT_STAT_ADDR, 32'h0);
    chk("status cleared", 32'h0, rd_v);
    // Input clock lost
    run <= 1'b0;
    cyc(40);
    apb(1'b0, pin_ctrl_pkg::STATUS_ADDR, 32'h0);
    chk("loss flag", 32'h0000_0001, 32'(rd_v[0]));
    chk("masked irq", 32'h0, 32'(irq));
    pinchk(12'h004, 1'b1, 1'b0);
    pinchk(12'h00c, 1'b1, 1'b1);
    apb(1'b1, pin_ctrl_pkg::INT_MASK_ADDR, 32'h0000_0001);
    cyc(2);
    chk("irq", 32'h0000_0001, 32'(irq));
    pinchk(12'h00d, 1'b1, 1'b0);
    pinchk(12'h00f, 1'b1, 1'b1);
    apb(1'b1, pin_ctrl_pkg::INT_MASK_ADDR, 32'h0);
    cyc(3);
    chk("masked pin", 32'h0, 32'(pin));
    apb(1'b1, pin_ctrl_pkg::INT_MASK_ADDR, 32'h0000_0001);
    apb(1'b1, pin_ctrl_pkg::INT_STAT_ADDR, 32'h0000_0001);
    cyc(3);
    chk("irq cleared", 32'h0, 32'(irq));
    chk("pin cleared", 32'h0, 32'(pin));
    // Input clock back
    run <= 1'b1;
    cyc(12);
    apb(1'b0, pin_ctrl_pkg::INT_STAT_ADDR, 32'h0);
    chk("loss fell", 32'h0000_0002, rd_v);
    pinchk(12'h00c, 1'b1, 1'b0);
    // Output enable, soft reset, then pin reset
    apb(1'b1, pin_ctrl_pkg::CTRL_ADDR, 32'h0000_0010);
    cyc(2);
    chk("clock out", 32'h0000_0001, 32'(cken));
    apb(1'b1, pin_ctrl_pkg::CTRL_ADDR, 32'h0000_0030);
    cyc(3);
    chk("soft reset clock", 32'h0, 32'(cken));
    apb(1'b0, pin_ctrl_pkg::CTRL_ADDR, 32'h0);
    chk("soft reset ctrl", 32'h0000_000a, rd_v);
    pinchk(12'h01c, 1'b1, 1'b0);
    ext_n <= 1'b0;
    cyc(4);
    chk("reset clock", 32'h0, 32'(cken));
    chk("reset pin", 32'h0, 32'(oe));
    chk("reset irq", 32'h0, 32'(irq));
    apb(1'b1, pin_ctrl_pkg::CTRL_ADDR, 32'h0000_0010);
    cyc(2);
    chk("held clock", 32'h0, 32'(cken));
    apb(1'b0, pin_ctrl_pkg::CTRL_ADDR, 32'h0);
    chk("held ctrl", 32'h0000_000a, rd_v);
    ext_n <= 1'b1;
    cyc(4);
    apb(1'b0, pin_ctrl_pkg::INT_MASK_ADDR, 32'h0);
    chk("mask reset", 32'h0, rd_v);
    chk("clock after reset", 32'h0, 32'(cken));
    end_sim();
  end
endmodule
`default_nettype wire
